// file: hdl/addr_store.sv
// four buffer addresses of the descriptor in flight; read data registered
module addr_store
   import rxsplit_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_idx,
   input  wire logic [63:0] wr_data,
   input  wire logic [1:0]  rd_idx,
   output logic      [63:0] rd_data
);
   typedef struct packed {
      logic [3:0][63:0] mem;
      logic [63:0]      rdata;
   } store_type;

   store_type r_reg, r_next;

   // write one slot, read registered
   always_comb begin
      r_next = r_reg;
      if (wr_en) begin
         r_next.mem[wr_idx] = wr_data;
      end
      r_next.rdata = r_reg.mem[rd_idx];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rd_data = r_reg.rdata;
endmodule

// file: hdl/frag_csum_select.sv
// picks packet checksum, ip ident and the four offload flags per packet type
module frag_csum_select
   import rxsplit_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic        ip_payload_checksum_enable,
   input  wire logic        checksum_start_offset_zero,
   input  wire logic        transport_offload_enable,
   input  wire logic        ipv4,
   input  wire logic        frag,
   input  wire logic        tcp,
   input  wire logic        udp,
   input  wire logic        udp_nz,
   input  wire logic [15:0] ipid,
   input  wire logic [15:0] csum_whole,
   input  wire logic [15:0] csum_payload,
   input  wire logic [15:0] csum_pseudo,
   output logic      [15:0] csum,
   output logic      [15:0] ipid_out,
   output logic      [3:0]  flags
);
   // flags order: udp_checksum_valid, ip_ident_valid, udp_checksummed, tcp_checksummed
   typedef struct packed {
      logic [15:0] csum;
      logic [15:0] ipid;
      logic [3:0]  flags;
   } sel_type;

   sel_type r_reg, r_next;

   // end-around-carry add; one fold is enough for two 16-bit operands
   function automatic logic [15:0] ones_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[15:0] + {15'b0, s[16]};
   endfunction

   // classify on load, hold otherwise
   always_comb begin
      logic auto_start;
      auto_start = ip_payload_checksum_enable && checksum_start_offset_zero;
      r_next = r_reg;
      if (load) begin
         r_next.csum  = csum_whole;
         r_next.ipid  = 16'h0000;
         r_next.flags = 4'h0;
         if (ipv4 && !frag) begin
            r_next.flags = {2'b00, transport_offload_enable && udp, transport_offload_enable && tcp};
         end else if (ipv4 && frag) begin
            r_next.ipid  = ipid;
            r_next.flags = 4'b0100;
            if (auto_start && udp) begin
               r_next.csum  = ones_add(csum_payload, csum_pseudo);
               r_next.flags = {udp_nz, 3'b110};
            end else if (auto_start && !tcp) begin
               r_next.csum  = csum_payload;
               r_next.flags = 4'b0110;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign csum     = r_reg.csum;
   assign ipid_out = r_reg.ipid;
   assign flags    = r_reg.flags;
endmodule

// file: hdl/rx_split_descriptor_writeback.sv
module rx_split_descriptor_writeback
   import rxsplit_pkg::*;
(
   input  wire logic        MCLK,
   input  wire logic        RST,
   input  wire logic [4:0]  REG_ADDR,
   input  wire logic [31:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [31:0] REG_RDATA,
   input  wire logic        DESC_VALID,
   input  wire logic [63:0] DESC_DATA,
   output logic             DESC_READY,
   input  wire logic        PKT_VALID,
   input  wire logic        PKT_EOP,
   input  wire logic [15:0] PKT_LEN,
   input  wire logic [9:0]  PKT_HDR_LEN,
   input  wire logic        PKT_IPV4,
   input  wire logic        PKT_FRAG,
   input  wire logic        PKT_TCP,
   input  wire logic        PKT_UDP,
   input  wire logic        PKT_UDP_CSUM_NZ,
   input  wire logic        PKT_VLAN_PRESENT,
   input  wire logic [15:0] PKT_VLAN,
   input  wire logic [15:0] PKT_IPID,
   input  wire logic [15:0] PKT_CSUM_WHOLE,
   input  wire logic [15:0] PKT_CSUM_PAYLOAD,
   input  wire logic [15:0] PKT_CSUM_PSEUDO,
   input  wire logic [31:0] PKT_RSS_HASH,
   input  wire logic [31:0] PKT_MRQ,
   input  wire logic [3:0]  PKT_ERR,
   output logic             PKT_READY,
   output logic             WB_VALID,
   output logic [1:0]       WB_INDEX,
   output logic [63:0]      WB_DATA,
   output logic [63:0]      WB_BUF_ADDR,
   output logic [15:0]      WB_BUF_LEN,
   output logic             SPLIT_MODE
);
`include "rxsplit_defs.svh"

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      state_type        state;
      logic [2:0]       cnt;
      logic [1:0]       widx;
      logic [31:0]      csum_ctl;
      logic [31:0]      filt_ctl;
      logic [31:0]      rx_ctl;
      logic [31:0]      split_ctl;
      logic [31:0]      rdata;
      logic [15:0]      desc_count;
      logic             cont;
      logic             split;
      logic             eop;
      logic             vp;
      logic             ipcs;
      logic [9:0]       header_byte_count;
      logic [3:0][15:0] len;
      logic [15:0]      vlan;
      logic [3:0]       err;
      logic [31:0]      rss;
      logic [31:0]      multi_queue_info;
      logic             mode;
      logic             desc_rdy;
      logic             pkt_rdy;
      logic             wb_valid;
      logic [1:0]       wb_index;
      logic [63:0]      wb_data;
      logic [63:0]      wb_addr;
      logic [15:0]      wb_len;
   } top_type;

   top_type r_reg, r_next;

   logic [63:0] mem_rdata;
   logic [15:0] pk_csum;
   logic [15:0] pk_ipid;
   logic [3:0]  pk_flags;

   function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   // buffer size in bytes from the 8-bit field in 128-byte units
   function automatic logic [15:0] bsize(input logic [31:0] ctl, input logic [1:0] i);
      logic [7:0] f;
      f = ctl[{i, 3'b000} +: 8];
      return {1'b0, f, 7'b000_0000};
   endfunction

   // -----------------------------------------------------------------
   // submodules
   // -----------------------------------------------------------------
   addr_store u_addr (
      .clk     (MCLK),
      .rst     (RST),
      .wr_en   (r_reg.desc_rdy && DESC_VALID),
      .wr_idx  (r_reg.widx),
      .wr_data (DESC_DATA),
      .rd_idx  (r_reg.cnt[1:0]),
      .rd_data (mem_rdata)
   );

   frag_csum_select u_csum (
      .clk          (MCLK),
      .rst          (RST),
      .load         (r_reg.pkt_rdy && PKT_VALID),
      .ip_payload_checksum_enable       (r_reg.csum_ctl[`CSUM_IP_PAYLOAD_CHECKSUM_ENABLE]),
      .checksum_start_offset_zero    (r_reg.csum_ctl[`CSUM_CHECKSUM_START_OFFSET_LSB +: 8] == 8'h00),
      .transport_offload_enable        (r_reg.csum_ctl[`CSUM_TRANSPORT_OFFLOAD_ENABLE]),
      .ipv4         (PKT_IPV4),
      .frag         (PKT_FRAG),
      .tcp          (PKT_TCP),
      .udp          (PKT_UDP),
      .udp_nz       (PKT_UDP_CSUM_NZ),
      .ipid         (PKT_IPID),
      .csum_whole   (PKT_CSUM_WHOLE),
      .csum_payload (PKT_CSUM_PAYLOAD),
      .csum_pseudo  (PKT_CSUM_PSEUDO),
      .csum         (pk_csum),
      .ipid_out     (pk_ipid),
      .flags        (pk_flags)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [15:0] rem;
      logic [15:0] take;
      logic        do_split;
      logic [1:0]  oi;
      logic [19:0] sta;
      logic [11:0] err;
      rem      = 16'h0000;
      take     = 16'h0000;
      do_split = 1'b0;
      oi       = 2'b00;
      sta      = 20'h0_0000;
      err      = 12'h000;
      r_next   = r_reg;
      r_next.rdata    = 32'h0000_0000;
      r_next.wb_valid = 1'b0;

      // register writes
      if (REG_WR) begin
         case (REG_ADDR)
            `OFF_CSUM_CTRL:  r_next.csum_ctl  = REG_WDATA & `CSUM_MASK;
            `OFF_FILT_CTRL:  r_next.filt_ctl  = REG_WDATA & `FILT_MASK;
            `OFF_RX_CTRL:    r_next.rx_ctl    = REG_WDATA & `RXC_MASK;
            `OFF_SPLIT_CTRL: r_next.split_ctl = REG_WDATA;
            default:         r_next.rdata     = 32'h0000_0000;
         endcase
      end
      // register reads, data valid the next cycle only; unmapped reads zero
      if (REG_RD) begin
         case (REG_ADDR)
            `OFF_CSUM_CTRL:  r_next.rdata = r_reg.csum_ctl;
            `OFF_FILT_CTRL:  r_next.rdata = r_reg.filt_ctl;
            `OFF_RX_CTRL:    r_next.rdata = r_reg.rx_ctl;
            `OFF_SPLIT_CTRL: r_next.rdata = r_reg.split_ctl;
            `OFF_STATUS:     r_next.rdata = {r_reg.desc_count, 11'h000, r_reg.mode,
                                             r_reg.state};
            default:         r_next.rdata = 32'h0000_0000;
         endcase
      end

      // split format is only legal with extended status and type 01b
      r_next.mode = r_reg.filt_ctl[`FILT_EXTENDED_STATUS_ENABLE] &&
                    (r_reg.rx_ctl[1:0] == `DESCRIPTOR_TYPE_SPLIT);

      case (r_reg.state)
         ST_IDLE: begin
            if (r_reg.mode) begin
               r_next.state = ST_FETCH;
               r_next.widx  = 2'b00;
            end
         end
         ST_FETCH: begin
            if (DESC_VALID) begin
               r_next.widx = r_reg.widx + 2'b01;
               if (r_reg.widx == 2'b11) begin
                  r_next.state = ST_WAIT;
               end
            end
         end
         ST_WAIT: begin
            if (PKT_VALID) begin
               // header must fit buffer 0 whole, and only a first descriptor splits
               do_split = (PKT_HDR_LEN != 10'h000) && !r_reg.cont &&
                          ({6'b0, PKT_HDR_LEN} <= bsize(r_reg.split_ctl, 2'b00));
               rem = do_split ? PKT_LEN - {6'b0, PKT_HDR_LEN} : PKT_LEN;
               r_next.len[0] = do_split ? {6'b0, PKT_HDR_LEN} : 16'h0000;
               for (int i = 0; i < 4; i++) begin
                  if ((i != 0) || (!do_split && !r_reg.cont)) begin
                     take = min16(rem, bsize(r_reg.split_ctl, 2'(i)));
                     r_next.len[i] = take;
                     rem = rem - take;
                  end
               end
               r_next.split = do_split;
               r_next.header_byte_count  = PKT_HDR_LEN;
               r_next.eop   = PKT_EOP;
               r_next.vp    = PKT_VLAN_PRESENT;
               r_next.vlan  = PKT_VLAN;
               r_next.ipcs  = PKT_IPV4;
               r_next.err   = PKT_ERR;
               r_next.rss   = PKT_RSS_HASH;
               r_next.multi_queue_info   = PKT_MRQ;
               r_next.cnt   = 3'h0;
               r_next.state = ST_WRITE;
            end
         end
         ST_WRITE: begin
            r_next.cnt = r_reg.cnt + 3'h1;
            if (r_reg.cnt != 3'h0) begin
               oi = 2'(r_reg.cnt - 3'h1);
               r_next.wb_valid = 1'b1;
               r_next.wb_index = oi;
               r_next.wb_addr  = mem_rdata;
               r_next.wb_len   = r_reg.len[oi];
               err[`ERR_RXE] = r_reg.err[3];
               err[`ERR_IPE] = r_reg.err[2];
               err[`ERR_L4]  = r_reg.err[1];
               err[`ERR_CE]  = r_reg.err[0];
               sta[`STA_DD]    = 1'b1;
               sta[`STA_EOP]   = r_reg.eop;
               sta[`STA_VP]    = r_reg.vp;
               sta[`STA_IPCS]  = r_reg.ipcs;
               sta[`STA_UDP_CHECKSUM_VALID]  = pk_flags[3];
               sta[`STA_IP_IDENT_VALID] = pk_flags[2];
               sta[`STA_UDP_CHECKSUMMED] = pk_flags[1];
               sta[`STA_TCP_CHECKSUMMED] = pk_flags[0];
               case (oi)
                  2'b00: r_next.wb_data = r_reg.csum_ctl[`CSUM_PACKET_CHECKSUM_DISABLE] ?
                                          {r_reg.rss, r_reg.multi_queue_info} :
                                          {pk_csum, pk_ipid, r_reg.multi_queue_info};
                  2'b01: r_next.wb_data = {r_reg.vlan, r_reg.len[0], err, sta};
                  2'b10: r_next.wb_data = {r_reg.len[3], r_reg.len[2], r_reg.len[1],
                                           r_reg.split, 5'b00000, r_reg.header_byte_count};
                  default: r_next.wb_data = 64'h0000_0000_0000_0000;
               endcase
            end
            if (r_reg.cnt == `WB_WORDS) begin
               r_next.cont       = !r_reg.eop;
               r_next.desc_count = r_reg.desc_count + 16'h0001;
               r_next.state      = ST_IDLE;
            end
         end
         default: r_next.state = ST_IDLE;
      endcase

      r_next.desc_rdy = (r_next.state == ST_FETCH);
      r_next.pkt_rdy  = (r_next.state == ST_WAIT);
   end

   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   always_ff @(posedge MCLK) begin
      if (RST) begin
         r_reg           <= '0;
         r_reg.state     <= ST_IDLE;
         r_reg.csum_ctl  <= `CSUM_RESET;
         r_reg.split_ctl <= `SPLIT_RESET;
      end else begin
         r_reg <= r_next;
      end
   end

   assign REG_RDATA   = r_reg.rdata;
   assign DESC_READY  = r_reg.desc_rdy;
   assign PKT_READY   = r_reg.pkt_rdy;
   assign WB_VALID    = r_reg.wb_valid;
   assign WB_INDEX    = r_reg.wb_index;
   assign WB_DATA     = r_reg.wb_data;
   assign WB_BUF_ADDR = r_reg.wb_addr;
   assign WB_BUF_LEN  = r_reg.wb_len;
   assign SPLIT_MODE  = r_reg.mode;

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   wire wb1 = WB_VALID && (WB_INDEX == 2'b01);

   property p_err_map;
      wb1 |-> (WB_DATA[31:20] == {r_reg.err[3:1], 4'h0, r_reg.err[0], 4'h0});
   endproperty
   a_err_map: assert property (p_err_map) else $error("error field mismatch");

   property p_err_zero;
      wb1 |-> (WB_DATA[28:25] == 4'h0) && (WB_DATA[23:20] == 4'h0);
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("reserved error bits set");

   property p_done;
      wb1 |-> WB_DATA[0] && (WB_DATA[47:32] == r_reg.len[0]);
   endproperty
   a_done: assert property (p_done) else $error("done flag or length 0 wrong");

   property p_reserved;
      WB_VALID && (WB_INDEX == 2'b11) |-> (WB_DATA == 64'h0000_0000_0000_0000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved word nonzero");

   property p_hash;
      WB_VALID && (WB_INDEX == 2'b00) && $past(r_reg.csum_ctl[`CSUM_PACKET_CHECKSUM_DISABLE])
         |-> (WB_DATA == {r_reg.rss, r_reg.multi_queue_info});
   endproperty
   a_hash: assert property (p_hash) else $error("hash word wrong");

   property p_fetch_gate;
      DESC_READY |-> $past(r_reg.mode) || $past(DESC_READY);
   endproperty
   a_fetch_gate: assert property (p_fetch_gate) else $error("fetch while disabled");

   property p_four_words;
      DESC_READY && DESC_VALID && (r_reg.widx == 2'b11) |=> !DESC_READY && PKT_READY;
   endproperty
   a_four_words: assert property (p_four_words) else $error("fetch length wrong");

   sequence s_burst;
      WB_VALID && (WB_INDEX == 2'b01) ##1 WB_VALID && (WB_INDEX == 2'b10)
      ##1 WB_VALID && (WB_INDEX == 2'b11) ##1 !WB_VALID;
   endsequence
   property p_burst;
      PKT_READY && PKT_VALID |-> ##3 (WB_VALID && (WB_INDEX == 2'b00)) ##1 s_burst;
   endproperty
   a_burst: assert property (p_burst) else $error("write-back burst wrong");

   property p_cont;
      WB_VALID && (WB_INDEX == 2'b10) && $past(r_reg.cont, 3) |-> !WB_DATA[15];
   endproperty
   a_cont: assert property (p_cont) else $error("continuation split");

   property p_hdr_fit;
      WB_VALID && (WB_INDEX == 2'b10) && WB_DATA[15]
         |-> ({6'b0, WB_DATA[9:0]} <= bsize(r_reg.split_ctl, 2'b00));
   endproperty
   a_hdr_fit: assert property (p_hdr_fit) else $error("header overflows buffer 0");

   c_split:   cover property (WB_VALID && (WB_INDEX == 2'b10) && WB_DATA[15]);
   c_cont:    cover property (WB_VALID && (WB_INDEX == 2'b01) && r_reg.cont);
   c_udpfrag: cover property (wb1 && WB_DATA[`STA_UDP_CHECKSUM_VALID]);
endmodule

// file: hdl/rxsplit_defs.svh
`ifndef RXSPLIT_DEFS_SVH
`define RXSPLIT_DEFS_SVH
// -----------------------------------------------------------------
// register offsets (byte addresses on the plain port)
// -----------------------------------------------------------------
`define OFF_CSUM_CTRL  5'h00
`define OFF_FILT_CTRL  5'h04
`define OFF_RX_CTRL    5'h08
`define OFF_SPLIT_CTRL 5'h0C
`define OFF_STATUS     5'h10
// -----------------------------------------------------------------
// field positions, write masks and reset values
// -----------------------------------------------------------------
`define CSUM_PACKET_CHECKSUM_DISABLE      0
`define CSUM_IP_PAYLOAD_CHECKSUM_ENABLE    1
`define CSUM_TRANSPORT_OFFLOAD_ENABLE     2
`define CSUM_CHECKSUM_START_OFFSET_LSB  8
`define CSUM_MASK      32'h0000_FF07
`define CSUM_RESET     32'h0000_0000
`define FILT_EXTENDED_STATUS_ENABLE    0
`define FILT_MASK      32'h0000_0001
`define RXC_MASK       32'h0000_0003
`define DESCRIPTOR_TYPE_SPLIT     2'h1
`define SPLIT_RESET    32'h0808_0808
`define BSIZE_SHIFT    7
// -----------------------------------------------------------------
// write-back layout
// -----------------------------------------------------------------
`define ERR_RXE        11
`define ERR_IPE        10
`define ERR_L4         9
`define ERR_CE         4
`define STA_DD         0
`define STA_EOP        1
`define STA_VP         3
`define STA_UDP_CHECKSUMMED      4
`define STA_TCP_CHECKSUMMED      5
`define STA_IPCS       6
`define STA_IP_IDENT_VALID      9
`define STA_UDP_CHECKSUM_VALID       10
`define EXT_ERR_LSB    20
`define HDR_SPLIT_BIT  15
`define WB_WORDS       3'h4
`endif

// file: hdl/rxsplit_pkg.sv
package rxsplit_pkg;
   // one-hot descriptor sequencer states
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_WAIT  = 4'b0100,
      ST_WRITE = 4'b1000
   } state_type;
endpackage

// file: testbench/host_mem_model.sv
// host side: hands out one four-word read-format descriptor after another
module host_mem_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        desc_ready,
   output logic             desc_valid,
   output logic [63:0]      desc_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [63:0] base_reg;
   logic [1:0]  idx_reg;
   logic        gap_reg;
   logic [63:0] addr;
   // page-aligned buffers keep address 1 lsb clear for the done flag
   assign addr = base_reg + {50'h0, idx_reg, 12'h000};
   // a stalled host shows the inverted address, never the held word
   assign desc_valid = ~gap_reg;
   assign desc_data  = gap_reg ? ~addr : addr;
   // words leave in offset order; slow mode inserts a gap after each word
   always_ff @(posedge clk) begin
      if (rst) begin
         base_reg <= 64'h0000_0001_0000_0000;
         idx_reg  <= 2'h0;
         gap_reg  <= 1'b0;
      end else begin
         gap_reg <= slow & desc_ready & ~gap_reg;
         if (desc_ready & ~gap_reg) begin
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == 2'h3) begin
               base_reg <= base_reg + 64'h0000_0000_0000_4000;
            end
         end
      end
   end
endmodule

// file: testbench/testbench.sv
`include "rxsplit_defs.svh"
module testbench;
   import rxsplit_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        MCLK = 1'b0, RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, slow = 1'b0;
   logic        PKT_VALID = 1'b0, PKT_EOP = 1'b0, PKT_IPV4 = 1'b0, PKT_FRAG = 1'b0;
   logic        PKT_TCP = 1'b0, PKT_UDP = 1'b0, PKT_UDP_CSUM_NZ = 1'b0, packet_checksum_disable = 1'b0;
   logic        PKT_VLAN_PRESENT = 1'b1;
   logic [4:0]  REG_ADDR = 5'h00;
   logic [31:0] REG_WDATA = 32'h0000_0000, PKT_RSS_HASH = 32'h0000_0000, REG_RDATA;
   logic [31:0] PKT_MRQ = 32'h0000_0000;
   logic [15:0] PKT_LEN = 16'h0000, PKT_VLAN = 16'h0000, PKT_IPID = 16'h0000;
   logic [15:0] PKT_CSUM_WHOLE = 16'h0000, PKT_CSUM_PAYLOAD = 16'h0000;
   logic [15:0] PKT_CSUM_PSEUDO = 16'h0000, WB_BUF_LEN;
   logic [9:0]  PKT_HDR_LEN = 10'h000;
   logic [3:0]  PKT_ERR = 4'h0;
   logic [63:0] DESC_DATA, WB_DATA, WB_BUF_ADDR;
   logic [1:0]  WB_INDEX;
   logic        DESC_VALID, DESC_READY, PKT_READY, WB_VALID, SPLIT_MODE;
   int          failures = 0, comparisons = 0, cycles = 0, pkt_num = 0;

   rx_split_descriptor_writeback DUT (.*);
   host_mem_model host (.clk(MCLK), .rst(RST), .slow(slow), .desc_ready(DESC_READY),
                        .desc_valid(DESC_VALID), .desc_data(DESC_DATA));
   always #25 MCLK = ~MCLK;
   // a hung handshake must still reach the verdict
   always @(posedge MCLK) begin
      cycles++;
      if (cycles > 5000) begin
         failures++;
         complete_run();
      end
   end
   // ----------------------------------------------------------------
   // compare, bus and packet tasks
   // ----------------------------------------------------------------
   task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
      @(posedge MCLK);
      REG_ADDR  <= a;
      REG_WDATA <= d;
      REG_WR    <= 1'b1;
      @(posedge MCLK);
      REG_WR    <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [4:0] a, input logic [31:0] exp);
      @(posedge MCLK);
      REG_ADDR <= a;
      REG_RD   <= 1'b1;
      @(posedge MCLK);
      REG_RD   <= 1'b0;
      @(posedge MCLK);
      check_reg(REG_RDATA, exp);
   endtask
   // kind {ipv4,frag,tcp,udp}; sel whole/payload/payload plus pseudo; fl {udp_checksum_valid,ip_ident_valid,udp_checksummed,tcp_checksummed}
   task automatic pkt(input logic [3:0] kind, input logic nz, input logic eop,
                      input logic [15:0] len, input logic [9:0] hl, input logic [3:0] err,
                      input logic [1:0] sel, input logic [3:0] fl, input logic [63:0] lens,
                      input logic split);
      logic [63:0] w [4];
      logic [63:0] base;
      logic [15:0] n;
      int          i;
      pkt_num++;
      n = pkt_num[15:0];
      base = 64'h0000_0001_0000_0000 + 64'(pkt_num - 1) * 64'h0000_0000_0000_4000;
      // udp fragments report payload plus pseudo header, end-around carry never occurs here
      w[0] = packet_checksum_disable ? {16'h5555, n, 16'h0000, n} :
             {(sel == 2'h2) ? (16'h4000 | n) + (16'h8000 | n) : {sel, n[13:0]},
              fl[2] ? 16'hA000 | n : 16'h0000, 16'h0000, n};
      w[1] = {8'h01, n[7:0], lens[15:0], err[3:1], 4'h0, err[0], 4'h0, 9'h000, fl[3], fl[2],
              2'h0, kind[3], fl[0], fl[1], 1'b1, 1'b0, eop, 1'b1};
      w[2] = {lens[63:16], split, 5'h00, hl};
      w[3] = 64'h0000_0000_0000_0000;
      @(posedge MCLK);
      {PKT_IPV4, PKT_FRAG, PKT_TCP, PKT_UDP, PKT_UDP_CSUM_NZ, PKT_EOP} <= {kind, nz, eop};
      {PKT_LEN, PKT_HDR_LEN, PKT_ERR, PKT_IPID, PKT_VLAN} <= {len, hl, err, 16'hA000 | n,
                                                             8'h01, n[7:0]};
      {PKT_CSUM_WHOLE, PKT_CSUM_PAYLOAD, PKT_CSUM_PSEUDO} <= {2'h0, n[13:0], 2'h1, n[13:0],
                                                             2'h2, n[13:0]};
      {PKT_RSS_HASH, PKT_MRQ} <= {16'h5555, n, 16'h0000, n};
      PKT_VALID <= 1'b1;
      i = 0;
      do @(posedge MCLK); while (PKT_READY !== 1'b1 && ++i < 60);
      PKT_VALID <= 1'b0;
      i = 0;
      do @(posedge MCLK); while (WB_VALID !== 1'b1 && ++i < 20);
      for (i = 0; i < 4; i++) begin
         check_word({61'h0, WB_VALID, WB_INDEX}, {61'h0, 1'b1, 2'(i)});
         check_word(WB_DATA, w[i]);
         check_word(WB_BUF_ADDR, base + 64'(i) * 64'h0000_0000_0000_1000);
         check_word({48'h0, WB_BUF_LEN}, {48'h0, lens[16*i +: 16]});
         @(posedge MCLK);
      end
   endtask
   task automatic complete_run();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge MCLK);
      RST <= 1'b0;
      reg_read(`OFF_SPLIT_CTRL, `SPLIT_RESET);
      reg_read(`OFF_CSUM_CTRL, `CSUM_RESET);
      reg_read(5'h14, 32'h0000_0000);
      reg_read(`OFF_STATUS, 32'h0000_0001);
      reg_write(`OFF_FILT_CTRL, 32'h0000_0001);
      reg_write(`OFF_RX_CTRL, 32'h0000_0002);
      repeat (3) @(posedge MCLK);
      check_reg({31'h0, SPLIT_MODE}, 32'h0000_0000);
      check_reg({31'h0, DESC_READY}, 32'h0000_0000);
      reg_write(`OFF_CSUM_CTRL, 32'h0000_0002);
      reg_read(`OFF_CSUM_CTRL, 32'h0000_0002);
      reg_write(`OFF_RX_CTRL, 32'h0000_0001);
      repeat (3) @(posedge MCLK);
      check_reg({31'h0, SPLIT_MODE}, 32'h0000_0001);
      $display("test registers done");
      pkt(4'h0, 1'b0, 1'b1, 16'h0064, 10'h000, 4'h9, 2'h0, 4'h0, 64'h64, 1'b0);
      pkt(4'hE, 1'b0, 1'b1, 16'h0040, 10'h000, 4'h6, 2'h0, 4'h4, 64'h40, 1'b0);
      pkt(4'hC, 1'b0, 1'b1, 16'h0040, 10'h000, 4'h0, 2'h1, 4'h6, 64'h40, 1'b0);
      pkt(4'hD, 1'b1, 1'b1, 16'h0040, 10'h000, 4'h0, 2'h2, 4'hE, 64'h40, 1'b0);
      pkt(4'hD, 1'b0, 1'b1, 16'h0040, 10'h000, 4'h0, 2'h2, 4'h6, 64'h40, 1'b0);
      $display("test checksum table done");
      slow <= 1'b1;
      pkt(4'h8, 1'b0, 1'b1, 16'h05DC, 10'h028, 4'h0, 2'h0, 4'h0,
          64'h0000_01B4_0400_0028, 1'b1);
      reg_write(`OFF_SPLIT_CTRL, 32'h0808_0801);
      pkt(4'h8, 1'b0, 1'b1, 16'h012C, 10'h0C8, 4'h0, 2'h0, 4'h0,
          64'h0000_0000_00AC_0080, 1'b0);
      pkt(4'h0, 1'b0, 1'b0, 16'h05DC, 10'h000, 4'h0, 2'h0, 4'h0,
          64'h0000_015C_0400_0080, 1'b0);
      pkt(4'h0, 1'b0, 1'b1, 16'h01F4, 10'h000, 4'h0, 2'h0, 4'h0,
          64'h0000_0000_01F4_0000, 1'b0);
      $display("test split done");
      packet_checksum_disable = 1'b1;
      reg_write(`OFF_CSUM_CTRL, 32'h0000_0003);
      pkt(4'h0, 1'b0, 1'b1, 16'h0040, 10'h000, 4'h0, 2'h0, 4'h0, 64'h40, 1'b0);
      $display("test hash done");
      complete_run();
   end
endmodule
